//--- rtl/tsa_top.v
// two-wire slave, register file and alert logic of the temperature sensor
// Notes on behaviour
// - shutdown plus trigger write starts one conversion
// - trigger reads zero while converting, one after
// - mode bit: zero comparator, one interrupt
// - comparator asserts after fault count highs
// - comparator clears after fault count lows
// - interrupt asserts after fault count highs
// - interrupt alert cleared by read, response, shutdown
// - after clear, watch lows and reassert
// - general call reset clears alert, mode
// - fault field selects one, two, four, six
// - polarity zero active low, one high
// - start and stop detected with scl high
// - seven address bits, rw, ack ninth
// - bytes are eight bits plus ack
// - address from address select pin
// - first written byte is pointer
// - reads use last stored pointer
// - msb byte sent first
// - answer alert response with own address
// - cause bit equals polarity for high
// - lose arbitration keeps alert asserted
// - general call 06h resets, aborts conversion
// - high-speed code not acked, high_speed flag set
// - high-speed ends on stop
// - scl low timeout resets serial side
// - pointer low bits select register
`timescale 1ns/10ps
`include "tsa_defines.vh"
module tsa_top #(
    parameter TIMEOUT_CYC = `TSA_TIMEOUT_CYC,
    parameter DEPTH       = 8
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        reset_n,
    // two-wire pins
    input  wire        scl_in,
    output wire        scl_out,
    output wire        scl_oe,
    input  wire        sda_in,
    output wire        sda_out,
    output reg         sda_oe,
    // address select pin, decoded to 0 gnd, 1 supply, 2 sda, 3 scl
    input  wire [1:0]  address_select_pin,
    // converter side
    output reg         conv_start,
    output reg         conv_abort,
    input  wire        result_valid,
    output wire        result_ready,
    input  wire [11:0] result_data,
    output wire        converting,
    // alert pin
    output wire        alert_out,
    output wire        alert_oe,
    // status
    output reg         high_speed
);
    localparam S_IDLE = 7'h01, S_ADDR = 7'h02, S_AACK = 7'h04, S_WR = 7'h08;
    localparam S_WACK = 7'h10, S_RD = 7'h20, S_RACK = 7'h40;
    reg  [2:0]  scl_s;
    reg  [2:0]  sda_s;
    reg  [3:0]  asel_reg;
    reg  [6:0]  st_reg;
    reg  [3:0]  bit_reg;
    reg  [7:0]  sh_reg;
    reg  [1:0]  bcnt_reg;
    reg         rw_reg, gcall_reg, aresp_reg, first_reg;
    reg  [1:0]  ptr_reg;
    reg  [7:0]  hold_reg;
    reg  [15:0] cfg_reg, hi_reg, lo_reg;
    reg  [11:0] temp_reg;
    reg  [15:0] tx_reg;
    reg         shot_busy;
    reg         alert_reg, low_side_reg;
    reg  [2:0]  fcnt_reg;
    reg  [31:0] to_reg;
    reg         clr_evt;
    wire scl_r = scl_s[1] & ~scl_s[2];
    wire scl_f = ~scl_s[1] & scl_s[2];
    wire start_c = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
    wire stop_c  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
    wire [6:0] my_addr = {`TSA_ADDR_BASE, asel_reg[3:2]};
    wire [7:0] cfg_hi = cfg_reg[15:8];
    wire [2:0] need = fault_need(cfg_hi[`TSA_CFG_F1:`TSA_CFG_F0]);
    wire alert_polarity = cfg_hi[`TSA_CFG_POL];
    wire mode_int = cfg_hi[`TSA_CFG_MODE];
    wire timeout = (to_reg >= TIMEOUT_CYC);
    wire busy_bus = (st_reg != S_IDLE);
    function [2:0] fault_need;
        input [1:0] f;
        begin
            case (f)
                2'b00:   fault_need = 3'd1;
                2'b01:   fault_need = 3'd2;
                2'b10:   fault_need = 3'd4;
                default: fault_need = 3'd6;
            endcase
        end
    endfunction
    function [15:0] reg_sel;
        input [1:0] p;
        begin
            case (p)
                `TSA_PTR_TEMP: reg_sel = {temp_reg, 4'h0};
                `TSA_PTR_CFG:  reg_sel = {cfg_reg[15:8] & 8'h7F, cfg_reg[7:0]}
                                         | {~shot_busy, 15'h0};
                `TSA_PTR_LOW:  reg_sel = lo_reg;
                default:       reg_sel = hi_reg;
            endcase
        end
    endfunction
    wire [15:0] rd_word = reg_sel(ptr_reg);
    assign scl_out  = 1'b0;
    assign scl_oe   = 1'b0;
    assign sda_out  = 1'b0;
    assign converting = shot_busy;
    // a result can only be accepted one per cycle; fifo drains each cycle
    wire       f_valid;
    wire [11:0] f_data;
    tsa_fifo #(.WIDTH(12), .DEPTH(DEPTH), .AW(3)) u_fifo (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .flush     (conv_abort),
        .in_valid  (result_valid),
        .in_ready  (result_ready),
        .in_data   (result_data),
        .out_valid (f_valid),
        .out_ready (1'b1),
        .out_data  (f_data)
    );
    // alert pin: open drain, polarity applied
    wire active_lvl = alert_polarity;
    wire pin_lvl = alert_reg ? active_lvl : ~active_lvl;
    assign alert_out = 1'b0;
    assign alert_oe  = ~pin_lvl;
    // pins sampled through two flops before use
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            asel_reg <= 4'h0;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            asel_reg <= {asel_reg[1:0], address_select_pin};
        end
    end
    // scl-low timeout, counted only between start and stop
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            to_reg <= 32'h0;
        end else if (!busy_bus || scl_s[1]) begin
            to_reg <= 32'h0;
        end else if (!timeout) begin
            to_reg <= to_reg + 32'h1;
        end
    end
    wire gc_fire = (st_reg == S_WACK) && scl_f && gcall_reg && (sh_reg == `TSA_GCALL_RESET);
    // serial engine
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= S_IDLE; bit_reg <= 4'h0; sh_reg <= 8'h0; sda_oe <= 1'b0;
            rw_reg <= 1'b0; gcall_reg <= 1'b0; aresp_reg <= 1'b0; first_reg <= 1'b0;
            bcnt_reg <= 2'h0; ptr_reg <= 2'h0; tx_reg <= 16'h0; hold_reg <= 8'h0;
            cfg_reg <= `TSA_CFG_RESET; hi_reg <= `TSA_HIGH_RESET; lo_reg <= `TSA_LOW_RESET;
            high_speed <= 1'b0; clr_evt <= 1'b0; conv_abort <= 1'b0;
        end else begin
            clr_evt <= 1'b0;
            conv_abort <= 1'b0;
            if (gc_fire) begin
                cfg_reg <= `TSA_CFG_RESET; hi_reg <= `TSA_HIGH_RESET;
                lo_reg <= `TSA_LOW_RESET; ptr_reg <= 2'h0; conv_abort <= 1'b1;
            end
            if (stop_c) begin
                high_speed <= 1'b0;
            end
            if (timeout || stop_c) begin
                st_reg <= S_IDLE; sda_oe <= 1'b0;
            end else if (start_c) begin
                st_reg <= S_ADDR; bit_reg <= 4'h0; first_reg <= 1'b1; sda_oe <= 1'b0;
            end else begin
                case (st_reg)
                    S_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    S_ADDR: if (scl_r) begin
                        sh_reg <= {sh_reg[6:0], sda_s[1]};
                        bit_reg <= bit_reg + 4'h1;
                    end else if (scl_f && bit_reg == 4'h8) begin
                        first_reg <= 1'b0;
                        rw_reg <= sh_reg[0];
                        gcall_reg <= (sh_reg[7:1] == `TSA_GCALL_ADDR) && !sh_reg[0];
                        aresp_reg <= (sh_reg[7:1] == `TSA_ALERT_RESP) && sh_reg[0];
                        bcnt_reg <= 2'h0; bit_reg <= 4'h0;
                        if (first_reg && (sh_reg & `TSA_HS_MASK) == `TSA_HS_CODE) begin
                            high_speed <= 1'b1;
                            st_reg <= S_IDLE;
                        end else if (sh_reg[7:1] == my_addr
                                     || ((sh_reg[7:1] == `TSA_GCALL_ADDR) && !sh_reg[0])
                                     || ((sh_reg[7:1] == `TSA_ALERT_RESP) && sh_reg[0]
                                         && mode_int && alert_reg)) begin
                            sda_oe <= 1'b1;
                            st_reg <= S_AACK;
                        end else begin
                            st_reg <= S_IDLE;
                        end
                    end
                    S_AACK: if (scl_f) begin
                        sda_oe <= 1'b0;
                        if (rw_reg) begin
                            tx_reg <= aresp_reg
                                ? {my_addr, low_side_reg ? ~alert_polarity : alert_polarity, 8'h0}
                                : rd_word;
                            if (!aresp_reg) clr_evt <= 1'b1;
                            st_reg <= S_RD;
                            sda_oe <= ~(aresp_reg ? my_addr[6]
                                                  : rd_word[15]);
                        end else begin
                            st_reg <= S_WR;
                        end
                    end
                    S_WR: if (scl_r) begin
                        sh_reg <= {sh_reg[6:0], sda_s[1]};
                        bit_reg <= bit_reg + 4'h1;
                    end else if (scl_f && bit_reg == 4'h8) begin
                        bit_reg <= 4'h0;
                        if (gcall_reg) begin
                            sda_oe <= (sh_reg == `TSA_GCALL_RESET);
                        end else begin
                            sda_oe <= 1'b1;
                            if (bcnt_reg == 2'h0) ptr_reg <= sh_reg[1:0];
                            else if (bcnt_reg == 2'h1) hold_reg <= sh_reg;
                            else if (ptr_reg == `TSA_PTR_CFG) begin
                                cfg_reg <= {hold_reg, sh_reg};
                                if (hold_reg[`TSA_CFG_SHUTDOWN]) clr_evt <= 1'b1;
                            end else if (ptr_reg == `TSA_PTR_LOW) lo_reg <= {hold_reg, sh_reg};
                            else if (ptr_reg == `TSA_PTR_HIGH) hi_reg <= {hold_reg, sh_reg};
                            if (bcnt_reg != 2'h3) bcnt_reg <= bcnt_reg + 2'h1;
                        end
                        st_reg <= S_WACK;
                    end
                    S_WACK: if (scl_f) begin
                        sda_oe <= 1'b0;
                        st_reg <= gcall_reg ? S_IDLE : S_WR;
                        if (bcnt_reg == 2'h3) bcnt_reg <= 2'h1;
                    end
                    S_RD: if (scl_f) begin
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == 4'h7) begin
                            sda_oe <= 1'b0;
                            st_reg <= S_RACK;
                        end else begin
                            tx_reg <= {tx_reg[14:0], 1'b0};
                            sda_oe <= ~tx_reg[14];
                        end
                    end
                    S_RACK: if (scl_r) begin
                        if (sda_s[1] || aresp_reg) st_reg <= S_IDLE; // nack ends read
                    end else if (scl_f) begin
                        bit_reg <= 4'h0;
                        tx_reg <= {tx_reg[14:0], 1'b0};
                        sda_oe <= ~tx_reg[14];
                        st_reg <= S_RD;
                    end
                    default: st_reg <= S_IDLE;
                endcase
            end
        end
    end
    // alert response: the device won if its bits stood on the line
    reg arb_lost;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            arb_lost <= 1'b0;
        end else if (st_reg == S_AACK) begin
            arb_lost <= 1'b0;
        end else if (aresp_reg && st_reg == S_RD && scl_r && !sda_oe && !sda_s[1]) begin
            arb_lost <= 1'b1;
        end
    end
    wire resp_done = aresp_reg && st_reg == S_RACK && scl_r && !arb_lost;
    // one-shot and conversion results
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shot_busy <= 1'b0; conv_start <= 1'b0; temp_reg <= 12'h0;
        end else begin
            conv_start <= 1'b0;
            if (conv_abort) begin
                shot_busy <= 1'b0; temp_reg <= 12'h0;
            end else if (st_reg == S_WR && scl_f && bit_reg == 4'h8 && !gcall_reg
                         && bcnt_reg == 2'h2 && ptr_reg == `TSA_PTR_CFG
                         && cfg_hi[`TSA_CFG_SHUTDOWN] && hold_reg[`TSA_CFG_SHOT]
                         && !shot_busy) begin
                shot_busy <= 1'b1;
                conv_start <= 1'b1;
            end else if (f_valid) begin
                temp_reg <= f_data;
                shot_busy <= 1'b0;
            end
        end
    end
    // alert state machine on each fresh result
    wire res_hi = ($signed(f_data) >= $signed(hi_reg[15:4]));
    wire res_lo = ($signed(f_data) <  $signed(lo_reg[15:4]));
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_reg <= 1'b0; low_side_reg <= 1'b0; fcnt_reg <= 3'h0;
        end else if (conv_abort) begin
            alert_reg <= 1'b0; low_side_reg <= 1'b0; fcnt_reg <= 3'h0;
        end else if (!mode_int) begin
            low_side_reg <= alert_reg;
            if (f_valid) begin
                if (alert_reg ? res_lo : res_hi) begin
                    if (fcnt_reg + 3'h1 >= need) begin
                        alert_reg <= ~alert_reg;
                        fcnt_reg <= 3'h0;
                    end else fcnt_reg <= fcnt_reg + 3'h1;
                end else fcnt_reg <= 3'h0;
            end
        end else begin
            // a fresh fault in the same cycle as a clear is not counted: clear wins
            if (f_valid && !alert_reg && (low_side_reg ? res_lo : res_hi)
                && fcnt_reg + 3'h1 >= need) begin
                alert_reg <= 1'b1;
                fcnt_reg <= 3'h0;
            end else if (alert_reg && (clr_evt || resp_done)) begin
                alert_reg <= 1'b0;
                low_side_reg <= ~low_side_reg;
                fcnt_reg <= 3'h0;
            end else if (f_valid && !alert_reg) begin
                fcnt_reg <= (low_side_reg ? res_lo : res_hi) ? fcnt_reg + 3'h1 : 3'h0;
            end
        end
    end
endmodule

//--- common/tsa_defines.vh
// constants for the sensor serial and alert block
`ifndef TSA_DEFINES_VH
`define TSA_DEFINES_VH
`define TSA_ADDR_BASE      5'h12
`define TSA_ALERT_RESP     7'h0C
`define TSA_GCALL_ADDR     7'h00
`define TSA_GCALL_RESET    8'h06
`define TSA_HS_MASK        8'hF8
`define TSA_HS_CODE        8'h08
`define TSA_PTR_TEMP       2'h0
`define TSA_PTR_CFG        2'h1
`define TSA_PTR_LOW        2'h2
`define TSA_PTR_HIGH       2'h3
`define TSA_CFG_SHUTDOWN   0
`define TSA_CFG_MODE       1
`define TSA_CFG_POL        2
`define TSA_CFG_F0         3
`define TSA_CFG_F1         4
`define TSA_CFG_SHOT       7
`define TSA_CFG_RESET      16'h60A0
`define TSA_HIGH_RESET     16'h5000
`define TSA_LOW_RESET      16'h4B00
`define TSA_TIMEOUT_MS     30
`define TSA_CLK_MHZ        100
`define TSA_TIMEOUT_CYC    (`TSA_TIMEOUT_MS * 1000 * `TSA_CLK_MHZ)
`endif

//--- rtl/tsa_fifo.v
// small valid/ready fifo for conversion results
`timescale 1ns/10ps
module tsa_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             reset_n,
    input  wire             flush,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_reg;
    reg [AW-1:0]    rd_reg;
    reg [AW:0]      cnt_reg;
    wire            push = in_valid && in_ready;
    wire            pop  = out_valid && out_ready;
    assign in_ready  = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    always @* begin
        out_data = mem[rd_reg];
    end
    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

//--- verif/tsa_monitor.sv
// concurrent checks on the sensor block's pins
`timescale 1ns/10ps
module tsa_monitor #(
    parameter TIMEOUT_CYC = 3000000
) (
    // clock and reset
    input wire sys_clk,
    input wire reset_n,
    // two-wire pins
    input wire scl_in,
    input wire sda_in,
    input wire sda_oe,
    // converter and alert
    input wire conv_start,
    input wire conv_abort,
    input wire alert_oe,
    input wire high_speed
);
    reg [31:0] low_cnt_reg;
    // saturating count of cycles with the clock line held low
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            low_cnt_reg <= 32'h0;
        else if (scl_in)
            low_cnt_reg <= 32'h0;
        else if (low_cnt_reg < TIMEOUT_CYC + 16)
            low_cnt_reg <= low_cnt_reg + 32'h1;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    property p_sda_moves_low; $changed(sda_oe) |-> !scl_in; endproperty
    a_sda_moves_low: assert property (p_sda_moves_low) else $error("data moved with clock high");
    property p_ack_stands; $rose(sda_oe) |=> sda_oe [*7]; endproperty
    a_ack_stands: assert property (p_ack_stands) else $error("data pull cut short");
    property p_hs_no_ack; $rose(high_speed) |-> !sda_oe [*8]; endproperty
    a_hs_no_ack: assert property (p_hs_no_ack) else $error("fast code was answered");
    property p_hs_stop; scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:8] !high_speed;
    endproperty
    a_hs_stop: assert property (p_hs_stop) else $error("fast mode kept past stop");
    property p_one_start; conv_start |=> !conv_start; endproperty
    a_one_start: assert property (p_one_start) else $error("start pulse too long");
    property p_abort_pulse; conv_abort |=> !conv_abort; endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse too long");
    property p_abort_clears; conv_abort |-> ##[0:4] !alert_oe; endproperty
    a_abort_clears: assert property (p_abort_clears) else $error("alert kept on reset");
    property p_reset_idle; $rose(reset_n) |-> !alert_oe && !sda_oe; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pins driven after reset");
    property p_timeout; low_cnt_reg == TIMEOUT_CYC + 16 |-> !sda_oe; endproperty
    a_timeout: assert property (p_timeout) else $error("data held past timeout");
    c_fast: cover property ($rose(high_speed));
    c_abort: cover property (conv_abort);
    c_ack: cover property ($rose(sda_oe));
endmodule
bind tsa_top tsa_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) tsa_monitor_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_oe(sda_oe), .conv_start(conv_start), .conv_abort(conv_abort),
    .alert_oe(alert_oe), .high_speed(high_speed));

//--- verif/tsa_bfm.sv
// two-wire bus master model for the sensor bench
`timescale 1ns/10ps
module tsa_bfm (
    // pacing clock
    input  wire sys_clk,
    // device pull-down on data
    input  wire dev_sda_oe,
    // bus levels, pulled up when released
    output reg  scl,
    output wire sda
);
    reg drive_low;
    assign sda = ~(drive_low | dev_sda_oe);
    initial begin
        scl = 1'b1;
        drive_low = 1'b0;
    end
    // quarter of a 160 ns bit
    task q;
        repeat (4) @(negedge sys_clk);
    endtask
    // also a repeated start; clock stands high between frames
    task start;
        begin
            drive_low = 1'b0;
            q;
            scl = 1'b1;
            q;
            drive_low = 1'b1;
            q;
            scl = 1'b0;
            q;
        end
    endtask
    task stop;
        begin
            drive_low = 1'b1;
            q;
            scl = 1'b1;
            q;
            drive_low = 1'b0;
            q;
        end
    endtask
    // data only moves while the clock is low
    task bit_io(input b, output r);
        begin
            drive_low = ~b;
            q;
            scl = 1'b1;
            q;
            r = sda;
            q;
            scl = 1'b0;
            q;
        end
    endtask
    task wr_byte(input [7:0] b, output ack);
        integer i;
        reg     r;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_io(b[i], r);
            bit_io(1'b1, r);
            ack = ~r;
        end
    endtask
    task rd_byte(output [7:0] b, input last);
        integer i;
        reg     r;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, b[i]);
            bit_io(last, r);
        end
    endtask
endmodule

//--- verif/testbench.sv
// self-checking bench for the sensor serial and alert block
`timescale 1ns/10ps
module testbench;
    reg         sys_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg  [1:0]  sel = 2'h0;
    reg         result_valid = 1'b0;
    reg  [11:0] result_data = 12'h000;
    wire        scl, sda, sda_oe, conv_start, conv_abort, result_ready, converting;
    wire        alert_oe, high_speed;
    integer     failures = 0, checks = 0, cyc = 0, starts = 0, aborts = 0, i, n;
    reg  [6:0]  dev = 7'h4B;
    reg         ack, ack0, alert_polarity;
    reg  [15:0] rd;
    always #5 sys_clk = ~sys_clk;
    tsa_top #(.TIMEOUT_CYC(2000), .DEPTH(8)) tsa_top_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl), .scl_out(), .scl_oe(),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .address_select_pin(sel),
        .conv_start(conv_start), .conv_abort(conv_abort), .result_valid(result_valid),
        .result_ready(result_ready), .result_data(result_data), .converting(converting),
        .alert_out(), .alert_oe(alert_oe), .high_speed(high_speed));
    tsa_bfm tsa_bfm_i (.sys_clk(sys_clk), .dev_sda_oe(sda_oe), .scl(scl), .sda(sda));
    task report_and_stop;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // ceiling is over four times the expected run
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (conv_start === 1'b1) starts = starts + 1;
        if (conv_abort === 1'b1) aborts = aborts + 1;
        if (cyc == 90000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // pin level equals polarity when active; the enable pulls it low
    task chk_alert(input act);
        chk({15'h0, alert_oe}, {15'h0, act ? ~alert_polarity : alert_polarity});
    endtask
    function [15:0] cfgw(input [1:0] f, input p, input m, input sd, input shot);
        cfgw = {shot, 2'b11, f, p, m, sd, 8'hA0};
    endfunction
    task ptr(input [1:0] p);
        begin
            tsa_bfm_i.start;
            tsa_bfm_i.wr_byte({dev, 1'b0}, ack);
            tsa_bfm_i.wr_byte({6'h0, p}, ack);
        end
    endtask
    task wr_reg(input [1:0] p, input [15:0] d);
        begin
            ptr(p);
            tsa_bfm_i.wr_byte(d[15:8], ack);
            tsa_bfm_i.wr_byte(d[7:0], ack);
            tsa_bfm_i.stop;
        end
    endtask
    task rd_cur(output [15:0] d);
        begin
            tsa_bfm_i.start;
            tsa_bfm_i.wr_byte({dev, 1'b1}, ack);
            tsa_bfm_i.rd_byte(d[15:8], 1'b0);
            tsa_bfm_i.rd_byte(d[7:0], 1'b1);
            tsa_bfm_i.stop;
        end
    endtask
    task rd_reg(input [1:0] p, output [15:0] d);
        begin
            ptr(p);
            rd_cur(d);
        end
    endtask
    task two_byte(input [7:0] a, input [7:0] b);
        begin
            tsa_bfm_i.start;
            tsa_bfm_i.wr_byte(a, ack0);
            tsa_bfm_i.wr_byte(b, ack);
            tsa_bfm_i.stop;
        end
    endtask
    task aresp(output [7:0] b);
        begin
            tsa_bfm_i.start;
            tsa_bfm_i.wr_byte(8'h19, ack);
            tsa_bfm_i.rd_byte(b, 1'b1);
            tsa_bfm_i.stop;
        end
    endtask
    // converter hands one result over the valid/ready pair
    task push(input [11:0] v);
        begin
            result_data = v;
            result_valid = 1'b1;
            @(posedge sys_clk);
            while (result_ready !== 1'b1) @(posedge sys_clk);
            @(negedge sys_clk);
            result_valid = 1'b0;
            repeat (20) @(negedge sys_clk);
        end
    endtask
    initial begin
        alert_polarity = 1'b0;
        repeat (4) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk({14'h0, alert_oe, sda_oe}, 16'h0);
        for (i = 0; i < 4; i = i + 1) begin
            sel = i[1:0];
            two_byte({5'h12, i[1:0] + 2'h1, 1'b0}, 8'h00);
            chk({15'h0, ack0}, 16'h0);
            two_byte({5'h12, i[1:0], 1'b0}, 8'h00);
            chk({15'h0, ack0}, 16'h1);
        end
        wr_reg(2'h3, 16'h6400);
        wr_reg(2'h2, 16'h3210);
        rd_reg(2'h3, rd);
        chk(rd, 16'h6400);
        rd_reg(2'h2, rd);
        rd_cur(rd);
        chk(rd, 16'h3210);
        push(12'h640);
        chk_alert(1'b1);
        wr_reg(2'h0, 16'hFFFF);
        rd_reg(2'h0, rd);
        chk(rd, 16'h6400);
        push(12'h100);
        chk_alert(1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            n = (i == 0) ? 1 : i * 2;
            wr_reg(2'h1, cfgw(i[1:0], 1'b0, 1'b0, 1'b0, 1'b0));
            repeat (n - 1) push(12'h700);
            chk_alert(1'b0);
            push(12'h700);
            chk_alert(1'b1);
            repeat (n - 1) push(12'h100);
            chk_alert(1'b1);
            push(12'h100);
            chk_alert(1'b0);
        end
        rd_reg(2'h1, rd);
        chk(rd & 16'h1F00, 16'h1800);
        alert_polarity = 1'b1;
        wr_reg(2'h1, cfgw(2'h0, 1'b1, 1'b1, 1'b0, 1'b0));
        chk_alert(1'b0);
        push(12'h700);
        chk_alert(1'b1);
        rd_cur(rd);
        chk_alert(1'b0);
        push(12'h700);
        chk_alert(1'b0);
        push(12'h100);
        chk_alert(1'b1);
        aresp(rd[7:0]);
        chk({7'h0, ack, rd[7:0]}, {8'h1, dev, ~alert_polarity});
        chk_alert(1'b0);
        push(12'h700);
        chk_alert(1'b1);
        aresp(rd[7:0]);
        chk({7'h0, ack, rd[7:0]}, {8'h1, dev, alert_polarity});
        push(12'h100);
        chk_alert(1'b1);
        wr_reg(2'h1, cfgw(2'h0, 1'b1, 1'b1, 1'b1, 1'b0));
        chk_alert(1'b0);
        starts = 0;
        wr_reg(2'h1, cfgw(2'h0, 1'b1, 1'b1, 1'b1, 1'b1));
        rd_cur(rd);
        chk({rd[15], converting, 14'h0}, 16'h4000);
        push(12'h200);
        rd_cur(rd);
        chk({rd[15], converting, starts[13:0]}, 16'h8001);
        alert_polarity = 1'b0;
        wr_reg(2'h1, cfgw(2'h0, 1'b0, 1'b0, 1'b0, 1'b0));
        push(12'h700);
        chk_alert(1'b1);
        two_byte(8'h00, 8'h07);
        chk({13'h0, ack0, ack, aborts[0]}, 16'h4);
        two_byte(8'h00, 8'h06);
        chk({13'h0, ack0, ack, aborts[0]}, 16'h7);
        chk_alert(1'b0);
        rd_reg(2'h1, rd);
        chk(rd, 16'hE0A0);
        tsa_bfm_i.start;
        tsa_bfm_i.wr_byte(8'h0B, ack);
        chk({14'h0, ack, high_speed}, 16'h1);
        tsa_bfm_i.start;
        tsa_bfm_i.wr_byte({dev, 1'b0}, ack);
        tsa_bfm_i.stop;
        repeat (8) @(negedge sys_clk);
        chk({14'h0, ack, high_speed}, 16'h2);
        rd[7:0] = {dev, 1'b0};
        tsa_bfm_i.start;
        for (i = 7; i >= 0; i = i - 1) tsa_bfm_i.bit_io(rd[i], ack);
        repeat (4) @(negedge sys_clk);
        chk({15'h0, sda_oe}, 16'h1);
        repeat (2100) @(negedge sys_clk);
        chk({15'h0, sda_oe}, 16'h0);
        tsa_bfm_i.stop;
        report_and_stop;
    end
endmodule
